// ==== rtl/fpf_flash_regs.v ====
`timescale 1ns/100ps
`include "fpf_defines.vh"
module fpf_flash_regs (
  input wire clk_i,
  input wire rst_n_i,
  input wire debug_mode_i,
  input wire [7:0] opt_data_i,
  input wire [3:0] sector_bits_i,
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg [5:0] opt_addr_o,
  output reg opt_loading_o,
  output reg [15:0] flash_addr_hi_o,
  output reg info_area_enable_o,
  output reg [6:0] erase_page_o,
  output reg erase_pulse_o,
  output reg [7:0] sector_protect_o,
  output reg [15:0] flash_clock_khz_o
);
  localparam ST_LOCKED = 6'b000001;
  localparam ST_FIRST = 6'b000010;
  localparam ST_SECOND = 6'b000100;
  localparam ST_UNLOCKED = 6'b001000;
  localparam ST_SECT = 6'b010000;
  localparam ST_ERASE = 6'b100000;

  reg [7:0] page_select_reg;
  reg [7:0] sector_protect_reg;
  reg [7:0] freq_high_byte;
  reg [7:0] freq_low_byte;
  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [15:0] option_reg;
  reg [5:0] opt_cnt_reg;
  reg [11:0] awaddr_reg;
  reg [7:0] wdata_reg;
  reg aw_have_reg;
  reg w_have_reg;
  reg [2:0] dbg_sync_reg;
  reg dbg_reg;
  wire [15:0] flash_clock_khz_value;
  wire wr_fire;
  wire wr_byte0;
  wire [11:0] wr_idx;
  wire [11:0] rd_idx;
  wire rd_known;
  wire timer_busy;
  wire timer_done;
  wire erase_start;
  reg [7:0] status_code;
  reg [7:0] rd_byte;
  reg [7:0] prot_allowed;

  // Write is performed once both address and data have arrived, in either order.
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
  assign wr_byte0 = s_axi_wstrb_i[0];
  assign wr_idx = {2'b00, awaddr_reg[11:2]} | 12'hc00;
  assign rd_idx = {2'b00, s_axi_araddr_i[11:2]} | 12'hc00;
  assign flash_clock_khz_value = {freq_high_byte, freq_low_byte};

  // Debug input is a pin; three flops, change accepted when last two agree.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_sync_reg <= 3'b000;
      dbg_reg <= 1'b0;
    end else begin
      dbg_sync_reg <= {dbg_sync_reg[1:0], debug_mode_i};
      if (dbg_sync_reg[1] == dbg_sync_reg[2]) begin
        dbg_reg <= dbg_sync_reg[2];
      end
    end
  end

  // Option load after reset.
  // Reads 43 flash bytes; the first two are the user option bytes and are kept here.
  // The remaining bytes are trim data, so only their addresses are driven from this block.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_cnt_reg <= 6'h00;
      opt_loading_o <= 1'b1;
      opt_addr_o <= 6'h00;
      option_reg <= 16'h0000;
    end else if (opt_loading_o) begin
      if (opt_cnt_reg == 6'h00) begin
        option_reg[7:0] <= opt_data_i;
      end else if (opt_cnt_reg == 6'h01) begin
        option_reg[15:8] <= opt_data_i;
      end
      if (opt_cnt_reg == `FPF_OPT_WIDTH - 6'd1) begin
        opt_loading_o <= 1'b0;
      end else begin
        opt_cnt_reg <= opt_cnt_reg + 6'h01;
        opt_addr_o <= opt_cnt_reg + 6'h01;
      end
    end
  end

  // Unlock sequence decoder.
  // Any write to the command register outside the expected order drops back to locked, except in the erase state, where it is ignored.
  always @* begin
    state_next = state_reg;
    if (timer_done) begin
      state_next = ST_LOCKED;
    end else if (wr_fire && wr_byte0 && wr_idx == `FPF_IDX_CMD && state_reg != ST_ERASE) begin
      state_next = ST_LOCKED;
      case (state_reg)
        ST_LOCKED: begin
          if (wdata_reg == `FPF_CMD_UNLOCK1) begin
            state_next = ST_FIRST;
          end else if (wdata_reg == `FPF_CMD_SECT_EN) begin
            state_next = ST_SECT;
          end
        end
        ST_FIRST: begin
          if (wdata_reg == `FPF_CMD_UNLOCK2) begin
            state_next = ST_SECOND;
          end
        end
        ST_SECOND, ST_UNLOCKED: begin
          if (wdata_reg == `FPF_CMD_PAGE_ERASE) begin
            state_next = ST_ERASE;
          end
        end
        default: begin
          state_next = ST_LOCKED;
        end
      endcase
    end else if (wr_fire && wr_byte0 && wr_idx == `FPF_IDX_PAGE) begin
      // A page write after the second unlock command completes unlocking.
      if (state_reg == ST_SECOND) begin
        state_next = ST_UNLOCKED;
      end else if (state_reg == ST_SECT) begin
        state_next = ST_LOCKED;
      end
    end
  end

  // Debug writes either value.
  // Outside debug the old bits are ORed in, so an attempt to clear leaves them set.
  always @* begin
    if (dbg_reg) begin
      prot_allowed = wdata_reg;
    end else begin
      prot_allowed = sector_protect_reg | wdata_reg;
    end
  end

  // Register updates; all reset to zero except the state, which resets to ST_LOCKED.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_LOCKED;
      page_select_reg <= `FPF_PAGE_RESET;
      sector_protect_reg <= `FPF_PROT_RESET;
      freq_high_byte <= `FPF_FREQ_RESET;
      freq_low_byte <= `FPF_FREQ_RESET;
    end else begin
      state_reg <= state_next;
      if (wr_fire && wr_byte0) begin
        if (wr_idx == `FPF_IDX_PAGE) begin
          if (state_reg == ST_SECT) begin
            sector_protect_reg <= prot_allowed;
          end else if (state_reg != ST_ERASE) begin
            page_select_reg <= wdata_reg;
          end
        end
        if (wr_idx == `FPF_IDX_FREQH) begin
          freq_high_byte <= wdata_reg;
        end
        if (wr_idx == `FPF_IDX_FREQL) begin
          freq_low_byte <= wdata_reg;
        end
      end
    end
  end

  // The return to locked lands one edge after done rises, so the erase state is still set while done is high.
  // Without this guard that edge would launch a second erase pulse on a page that may then change.
  assign erase_start = (state_reg == ST_ERASE) && !timer_done;

  // Erase pulse timing from kilohertz value.
  fpf_pulse_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(erase_start),
    .freq_khz_i(flash_clock_khz_value),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // Outputs to the flash array, registered.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_addr_hi_o <= 16'h0000;
      info_area_enable_o <= 1'b0;
      erase_page_o <= 7'h00;
      erase_pulse_o <= 1'b0;
      sector_protect_o <= 8'h00;
      flash_clock_khz_o <= 16'h0000;
    end else begin
      flash_addr_hi_o <= {page_select_reg[6:0], 9'h000};
      info_area_enable_o <= page_select_reg[`FPF_INFO_BIT];
      erase_page_o <= page_select_reg[6:0];
      // Under debug the erase pulse ignores protection; sector_protect_o still shows the locked sectors then.
      erase_pulse_o <= timer_busy && (dbg_reg || !sector_protect_reg[page_select_reg[2:0]]);
      sector_protect_o <= sector_protect_reg & {{4{sector_bits_i[3]}}, {2{sector_bits_i[1]}}, 2'b11};
      flash_clock_khz_o <= flash_clock_khz_value;
    end
  end

  // Status code presented at the command address.
  // The erase code keeps its low three bits zero, since no program operation exists in this block.
  always @* begin
    case (state_reg)
      ST_LOCKED: status_code = {2'b00, `FPF_ST_LOCKED};
      ST_FIRST: status_code = {2'b00, `FPF_ST_FIRST};
      ST_SECOND: status_code = {2'b00, `FPF_ST_SECOND};
      ST_UNLOCKED: status_code = {2'b00, `FPF_ST_UNLOCKED};
      ST_SECT: status_code = {2'b00, `FPF_ST_SECT};
      ST_ERASE: status_code = {2'b00, `FPF_ST_ERASE};
      default: status_code = 8'h00;
    endcase
  end

  // Read mux; the shared address reads back the page select value.
  always @* begin
    case (rd_idx)
      `FPF_IDX_CMD: rd_byte = status_code;
      `FPF_IDX_PAGE: rd_byte = page_select_reg;
      `FPF_IDX_FREQH: rd_byte = freq_high_byte;
      `FPF_IDX_FREQL: rd_byte = freq_low_byte;
      `FPF_IDX_OPT: rd_byte = option_reg[7:0];
      `FPF_IDX_OP: rd_byte = sector_protect_reg;
      default: rd_byte = 8'h00;
    endcase
  end
  assign rd_known = (rd_idx >= `FPF_IDX_OPT && rd_idx <= `FPF_IDX_OP) ||
                    (rd_idx >= `FPF_IDX_CMD && rd_idx <= `FPF_IDX_FREQL);

  // AXI write channel: capture address and data independently, respond after both.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 8'h00;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `FPF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        awaddr_reg <= s_axi_awaddr_i;
        aw_have_reg <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        wdata_reg <= s_axi_wdata_i[7:0];
        w_have_reg <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= ((wr_idx >= `FPF_IDX_CMD && wr_idx <= `FPF_IDX_FREQL) ? `FPF_RESP_OKAY
                          : `FPF_RESP_SLVERR);
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // AXI read channel: one read at a time, answer one cycle after acceptance.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `FPF_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h000000, rd_byte};
        s_axi_rresp_o <= rd_known ? `FPF_RESP_OKAY : `FPF_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule // fpf_flash_regs

// ==== rtl/fpf_pulse_timer.v ====
`timescale 1ns/100ps
`include "fpf_defines.vh"
// Counts an erase pulse: freq_khz cycles form one millisecond, repeated FPF_ERASE_MS times.
module fpf_pulse_timer (
  input wire clk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [15:0] freq_khz_i,
  output reg busy_o,
  output reg done_o
);
  reg [15:0] tick_reg;
  reg [15:0] ms_reg;

  // A zero frequency still ends after one tick per millisecond rather than hanging.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_reg <= 16'h0000;
      ms_reg <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        tick_reg <= 16'h0000;
        ms_reg <= 16'h0000;
      end else if (busy_o) begin
        if (tick_reg + 16'h0001 >= freq_khz_i) begin
          tick_reg <= 16'h0000;
          if (ms_reg + 16'h0001 >= `FPF_ERASE_MS) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else begin
            ms_reg <= ms_reg + 16'h0001;
          end
        end else begin
          tick_reg <= tick_reg + 16'h0001;
        end
      end
    end
  end
endmodule // fpf_pulse_timer

// ==== shared/fpf_defines.vh ====
`ifndef FPF_DEFINES_VH
`define FPF_DEFINES_VH
// Printed offsets are not multiples of four, so they are indices; byte address is index times four.
`define FPF_IDX_CMD 12'hff8
`define FPF_IDX_PAGE 12'hff9
`define FPF_IDX_FREQH 12'hffa
`define FPF_IDX_FREQL 12'hffb
`define FPF_IDX_OPT 12'hff0
`define FPF_IDX_OP 12'hff1
`define FPF_CMD_UNLOCK1 8'h73
`define FPF_CMD_UNLOCK2 8'h8c
`define FPF_CMD_PAGE_ERASE 8'h95
`define FPF_CMD_SECT_EN 8'h5e
`define FPF_ST_LOCKED 6'h00
`define FPF_ST_FIRST 6'h01
`define FPF_ST_SECOND 6'h02
`define FPF_ST_UNLOCKED 6'h03
`define FPF_ST_SECT 6'h04
`define FPF_ST_ERASE 6'h10
`define FPF_PAGE_RESET 8'h00
`define FPF_PROT_RESET 8'h00
`define FPF_FREQ_RESET 8'h00
`define FPF_INFO_BIT 7
`define FPF_OPT_WIDTH 6'd43
`define FPF_ERASE_MS 16'd10
`define FPF_RESP_OKAY 2'b00
`define FPF_RESP_SLVERR 2'b10
`endif

// ==== verification/fpf_flash_model.sv ====
`timescale 1ns/100ps
// Flash array as seen by the option loader: one byte per address.
module fpf_flash_model (
  input wire clk_i,
  input wire loading_i,
  input wire [5:0] addr_i,
  output wire [7:0] data_o
);
  reg [7:0] junk_reg = 8'h5a;
  // Unaddressed outside the load, so the lines churn rather than hold a value.
  always @(posedge clk_i) begin
    junk_reg <= junk_reg + 8'h3b;
  end
  assign data_o = loading_i ? ({2'b10, addr_i} ^ 8'h25) : junk_reg;
endmodule // fpf_flash_model

// ==== verification/fpf_regs_props.sv ====
`timescale 1ns/100ps
// Port checker for the flash register block; erase length is counted in helper logic.
module fpf_regs_props (
  input wire clk_i,
  input wire rst_n_i,
  input wire debug_mode_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o,
  input wire opt_loading_o,
  input wire [5:0] opt_addr_o,
  input wire [15:0] flash_addr_hi_o,
  input wire [6:0] erase_page_o,
  input wire erase_pulse_o,
  input wire [7:0] sector_protect_o,
  input wire [15:0] flash_clock_khz_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  reg [19:0] run_cnt_reg;
  // Length of the erase pulse so far; cleared while the pulse is low.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) run_cnt_reg <= 20'h0;
    else if (erase_pulse_o) run_cnt_reg <= run_cnt_reg + 20'h1;
    else run_cnt_reg <= 20'h0;
  end
  a_write_answer: assert property (s_wr_take |=> !s_axi_awready_o ##1 s_axi_bvalid_o)
    else $error("write response late");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read data late");
  a_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  a_byte_only: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_page_addr: assert property (flash_addr_hi_o == {erase_page_o, 9'h0})
    else $error("address bits differ from page");
  a_prot_sticky: assert property (!debug_mode_i [*6] |=>
    (sector_protect_o & $past(sector_protect_o)) == $past(sector_protect_o))
    else $error("protect bit cleared");
  a_erase_page: assert property (erase_pulse_o && $past(erase_pulse_o) |-> $stable(erase_page_o))
    else $error("page moved during erase");
  a_erase_len: assert property ($fell(erase_pulse_o) && flash_clock_khz_o != 16'h0 |->
    run_cnt_reg == 20'd10 * flash_clock_khz_o)
    else $error("erase length wrong");
  a_opt_range: assert property (opt_loading_o |-> opt_addr_o <= 6'd42)
    else $error("option address out of range");
endmodule // fpf_regs_props
bind fpf_flash_regs fpf_regs_props u_props (.*);

// ==== verification/tb.sv ====
`timescale 1ns/100ps
// Register tests over AXI4-Lite against the flash register block.
module tb;
  localparam [11:0] ic = 12'hff8, ip = 12'hff9, ih = 12'hffa, il = 12'hffb, io = 12'hff1;
  reg clk_i = 1'b0, rst_n_i = 1'b0, debug_mode_i = 1'b0;
  reg s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  reg s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  reg [11:0] s_axi_awaddr_i = 12'h0, s_axi_araddr_i = 12'h0;
  reg [31:0] s_axi_wdata_i = 32'h0;
  reg [3:0] s_axi_wstrb_i = 4'hf, sector_bits_i = 4'hf;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire opt_loading_o, info_area_enable_o, erase_pulse_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire [5:0] opt_addr_o;
  wire [7:0] opt_data_i, sector_protect_o;
  wire [15:0] flash_addr_hi_o, flash_clock_khz_o;
  wire [6:0] erase_page_o;
  int num_errors = 0, num_checks = 0, cyc = 0;
  reg [31:0] got;
  reg [1:0] resp;
  fpf_flash_regs u_dut (.*);
  fpf_flash_model u_mem (.clk_i(clk_i), .loading_i(opt_loading_o), .addr_i(opt_addr_o), .data_o(opt_data_i));
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  task chk(input string n, input [31:0] e, input [31:0] a);
    begin
      num_checks++;
      if (a !== e) begin
        num_errors++;
        $display("unexpected %s: expected %h, seen %h", n, e, a);
      end
    end
  endtask
  task wr(input [11:0] idx, input [7:0] d);
    begin
      @(posedge clk_i);
      s_axi_awaddr_i <= {idx[9:0], 2'b00};
      s_axi_wdata_i <= {24'h0, d};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do begin
        @(posedge clk_i);
        if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
        if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (!s_axi_bvalid_o);
      resp = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
    end
  endtask
  task rd(input [11:0] idx);
    begin
      @(posedge clk_i);
      s_axi_araddr_i <= {idx[9:0], 2'b00};
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do begin
        @(posedge clk_i);
        if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!s_axi_rvalid_o);
      got = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
    end
  endtask
  task rc(input string n, input [11:0] idx, input [7:0] e);
    begin
      rd(idx);
      chk(n, {24'h0, e}, got);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Cuts a hung handshake short; the whole run needs well under this.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  // Main sequence; the option load is allowed to finish first.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (45) @(posedge clk_i);
    rc("prot", io, 8'h00);
    rc("page", ip, 8'h00);
    rc("stat", ic, 8'h00);
    rc("opt0", 12'hff0, 8'ha5);
    wr(ih, 8'h12);
    wr(il, 8'h34);
    repeat (2) @(posedge clk_i);
    chk("khz", 32'h1234, {16'h0, flash_clock_khz_o});
    rc("freql", il, 8'h34);
    wr(ih, 8'h00);
    wr(il, 8'h0a);
    wr(ip, 8'h85);
    repeat (2) @(posedge clk_i);
    chk("info", 32'h1, {31'h0, info_area_enable_o});
    chk("addr", 32'h0a00, {16'h0, flash_addr_hi_o});
    rc("page", ip, 8'h85);
    wr(ic, 8'h73);
    rc("st1", ic, 8'h01);
    wr(ic, 8'h8c);
    rc("st2", ic, 8'h02);
    wr(ip, 8'h02);
    rc("st3", ic, 8'h03);
    wr(ic, 8'h95);
    rc("st4", ic, 8'h10);
    chk("pulse", 32'h1, {31'h0, erase_pulse_o});
    chk("epage", 32'h2, {25'h0, erase_page_o});
    wr(ip, 8'h7f);
    repeat (110) @(posedge clk_i);
    rc("st5", ic, 8'h00);
    rc("page", ip, 8'h02);
    wr(ic, 8'h73);
    wr(ic, 8'h11);
    rc("bad", ic, 8'h00);
    wr(ic, 8'h5e);
    rc("st6", ic, 8'h04);
    wr(ip, 8'h0a);
    rc("prot", io, 8'h0a);
    rc("page", ip, 8'h02);
    wr(ic, 8'h5e);
    wr(ip, 8'h01);
    rc("prot", io, 8'h0b);
    chk("ppin", 32'h0b, {24'h0, sector_protect_o});
    wr(ip, 8'h03);
    rc("page", ip, 8'h03);
    debug_mode_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    sector_bits_i <= 4'h0;
    repeat (2) @(posedge clk_i);
    chk("ppin1", 32'h03, {24'h0, sector_protect_o});
    sector_bits_i <= 4'hf;
    wr(ic, 8'h5e);
    wr(ip, 8'h00);
    rc("prot", io, 8'h00);
    debug_mode_i <= 1'b0;
    rd(12'hff5);
    chk("rresp", 32'h2, {30'h0, resp});
    wr(12'hff5, 8'h55);
    chk("bresp", 32'h2, {30'h0, resp});
    wr(ic, 8'h5e);
    wr(ip, 8'h30);
    rc("prot", io, 8'h30);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (45) @(posedge clk_i);
    rc("prot", io, 8'h00);
    end_sim;
  end
endmodule // tb
